// *** rslv_core.sv ***
`include "rslv_params.svh"
`default_nettype none

module rslv_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_n,
  input wire logic wdog_timeout,
  input wire logic watchdog_action_option,
  input wire logic stop_mode,
  input wire logic brownout_raw,
  input wire logic low_voltage_raw,
  output logic sys_reset,
  output logic irq,
  output logic [7:0] wdog_ctrl,
  output logic wdog_ctrl_wr
);

  // ---------------------------------------------------------------
  // Pin and detector synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pin_sync_r;
  logic [2:0] bo_sync_r;
  logic [2:0] lv_sync_r;
  logic pin_low_r;
  logic bo_r;
  logic lv_r;

  // Pin stages reset high, the pull-up idle level, so the release of
  // presetn is not taken for a pin reset; detectors reset quiet.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_r <= 3'h7;
      bo_sync_r <= 3'h0;
      lv_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], reset_pin_n};
      bo_sync_r <= {bo_sync_r[1:0], brownout_raw};
      lv_sync_r <= {lv_sync_r[1:0], low_voltage_raw};
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_low_r <= 1'b0;
      bo_r <= 1'b0;
      lv_r <= 1'b0;
    end else begin
      if (pin_sync_r[1] == pin_sync_r[2]) begin
        pin_low_r <= ~pin_sync_r[2];
      end
      if (bo_sync_r[1] == bo_sync_r[2]) begin
        bo_r <= bo_sync_r[2];
      end
      if (lv_sync_r[1] == lv_sync_r[2]) begin
        lv_r <= lv_sync_r[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  rslv_pkg::rslv_ctrl_s ctrl_r;
  logic wr_en;
  logic rd_en;

  // Each transfer holds penable for two cycles; acting only in the one
  // that carries pready makes a write, a strobe and a read clear happen
  // exactly once per transfer.
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && pready && !pwrite;

  // Address match, shared by every register strobe below
  function automatic logic addr_hit(
    input logic [11:0] addr,
    input logic [11:0] target
  );
    return addr == target;
  endfunction

  logic wr_cause;
  logic wr_ctrl;
  logic wr_irq_clr;
  logic wr_irq_en;

  assign wr_cause = wr_en && addr_hit(paddr, `RSLV_ADDR_CAUSE);
  assign wr_ctrl = wr_en && addr_hit(paddr, `RSLV_ADDR_CTRL);
  assign wr_irq_clr = wr_en && addr_hit(paddr, `RSLV_ADDR_IRQ_CLR);
  assign wr_irq_en = wr_en && addr_hit(paddr, `RSLV_ADDR_IRQ_EN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= rslv_pkg::rslv_ctrl_s'(`RSLV_CTRL_RESET);
    end else if (wr_ctrl) begin
      ctrl_r.bo_en <= pwdata[`RSLV_CTRL_BO_EN];
      ctrl_r.lvd_ie <= pwdata[`RSLV_CTRL_LVD_IE];
    end
  end

  // Shared circuitry: brownout off silences the low-voltage path too
  logic bo_active;
  logic lv_active;
  assign bo_active = ctrl_r.bo_en && bo_r;
  assign lv_active = ctrl_r.bo_en && lv_r;

  // ---------------------------------------------------------------
  // Glitch filter on the reset pin
  // ---------------------------------------------------------------
  // Synchroniser adds latency, so three clocks of low already count.
  // The counter saturates, so a pin held low for long never wraps and
  // never fires a second request while it stays low.
  logic [2:0] low_cnt_r;
  logic pin_req;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_r <= 3'h0;
    end else if (!pin_low_r) begin
      low_cnt_r <= 3'h0;
    end else if (low_cnt_r != `RSLV_GLITCH_CYC) begin
      low_cnt_r <= low_cnt_r + 3'h1;
    end
  end

  assign pin_req = pin_low_r && (low_cnt_r == `RSLV_EXT_MIN_CYC - 3'h1);

  // ---------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------
  rslv_pkg::rslv_seq_e state_r;
  logic [3:0] seq_cnt_r;
  logic wdog_req;
  logic any_req;

  // Watchdog resets only with watchdog_action_option set and outside stop mode; with the option clear it raises an interrupt
  assign wdog_req = wdog_timeout && watchdog_action_option
                    && !stop_mode;
  assign any_req = wdog_req || pin_req || bo_active;

  // A request that arrives during the tail opens no new sequence; only a
  // brownout or a low pin restarts the tail count. The sequence already holds
  // the system, and the cause register keeps the source that opened it.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= rslv_pkg::RSLV_HOLD;
      seq_cnt_r <= 4'h0;
    end else begin
      unique case (state_r)
        rslv_pkg::RSLV_RUN: begin
          if (any_req) begin
            state_r <= rslv_pkg::RSLV_HOLD;
            seq_cnt_r <= 4'h0;
          end
        end
        rslv_pkg::RSLV_HOLD: begin
          // Held while brownout or pin stays low, then a fixed tail
          if (bo_active || pin_low_r) begin
            seq_cnt_r <= 4'h0;
          end else if (seq_cnt_r == `RSLV_SEQ_CYC - 4'h1) begin
            state_r <= rslv_pkg::RSLV_DONE;
          end else begin
            seq_cnt_r <= seq_cnt_r + 4'h1;
          end
        end
        rslv_pkg::RSLV_DONE: begin
          // One cycle here lets sys_reset fall before requests count
          // again
          state_r <= rslv_pkg::RSLV_RUN;
        end
        default: begin
          state_r <= rslv_pkg::RSLV_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset <= 1'b1;
    end else begin
      sys_reset <= (state_r == rslv_pkg::RSLV_HOLD) || any_req;
    end
  end

  // ---------------------------------------------------------------
  // Reset-cause register
  // ---------------------------------------------------------------
  logic [7:0] cause_r;
  logic cause_rd;

  assign cause_rd = rd_en && addr_hit(paddr, `RSLV_ADDR_CAUSE);

  // Read data is captured in the first access cycle, so the clear in
  // the second one never hides the flags from the reader. The value is
  // cleared once per read, never by a write to the shared address.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r <= `RSLV_CAUSE_POR_VAL;
    end else if (state_r == rslv_pkg::RSLV_RUN && any_req) begin
      // Latest reset source wins over a pending read clear
      cause_r <= 8'h00;
      cause_r[`RSLV_BIT_WDOG] <= wdog_req;
      cause_r[`RSLV_BIT_POR] <= bo_active;
      cause_r[`RSLV_BIT_EXT] <= pin_req && !stop_mode;
      cause_r[`RSLV_BIT_STOP] <= pin_req && stop_mode;
    end else if (cause_rd) begin
      cause_r <= cause_r & ~`RSLV_CAUSE_HI_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic [`RSLV_IRQ_W-1:0] irq_stat_r;
  logic [`RSLV_IRQ_W-1:0] irq_en_r;
  logic [`RSLV_IRQ_W-1:0] irq_set;
  logic [`RSLV_IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[`RSLV_IRQ_WDOG] = wdog_timeout
                              && !watchdog_action_option;
    irq_set[`RSLV_IRQ_LVD] = lv_active && ctrl_r.lvd_ie;
  end

  // Status bits are sticky; software clears them by writing ones
  always_comb begin
    irq_clr = '0;
    if (wr_irq_clr) begin
      irq_clr = pwdata[`RSLV_IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else begin
      // Set wins over a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= '0;
    end else if (wr_irq_en) begin
      irq_en_r <= pwdata[`RSLV_IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      // Look-ahead on set and clear keeps the pin in step with status
      irq <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
    end
  end

  // ---------------------------------------------------------------
  // Watchdog control write port and APB read
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_ctrl <= 8'h00;
      wdog_ctrl_wr <= 1'b0;
    end else begin
      // The byte is write-only here; the strobe lets the watchdog
      // latch it once per transfer.
      wdog_ctrl_wr <= wr_cause;
      if (wr_cause) begin
        wdog_ctrl <= pwdata[7:0];
      end
    end
  end

  logic addr_ok;
  logic [31:0] rd_val;

  always_comb begin
    addr_ok = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `RSLV_ADDR_CAUSE: begin
        rd_val[7:0] = cause_r;
        rd_val[`RSLV_BIT_LVD] = lv_active;
      end
      `RSLV_ADDR_CTRL: begin
        rd_val[`RSLV_CTRL_BO_EN] = ctrl_r.bo_en;
        rd_val[`RSLV_CTRL_LVD_IE] = ctrl_r.lvd_ie;
      end
      `RSLV_ADDR_IRQ_STAT: rd_val[`RSLV_IRQ_W-1:0] = irq_stat_r;
      `RSLV_ADDR_IRQ_CLR: rd_val = 32'h0000_0000;
      `RSLV_ADDR_IRQ_EN: rd_val[`RSLV_IRQ_W-1:0] = irq_en_r;
      default: addr_ok = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  // Writes and the read clear act in that second access cycle only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      prdata <= (psel && penable && !pready && !pwrite) ? rd_val
                : 32'h0000_0000;
    end
  end

endmodule // rslv_core
`default_nettype wire

// *** rslv_core_asserts.sv ***
`include "rslv_params.svh"
`default_nettype none
module rslv_core_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reset_pin_n,
  input wire logic wdog_timeout,
  input wire logic watchdog_action_option,
  input wire logic brownout_raw,
  input wire logic sys_reset,
  input wire logic wdog_ctrl_wr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_wdog_reset_on: assert property (
    wdog_timeout && watchdog_action_option |-> ##[0:4] sys_reset)
    else $error("watchdog timeout gave no system reset");
  a_wdog_irq_only: assert property (
    wdog_timeout && !watchdog_action_option && !sys_reset && reset_pin_n
    && !brownout_raw |=> !sys_reset)
    else $error("watchdog interrupt mode still reset");
  a_seq_hold: assert property (
    $rose(sys_reset) |=> sys_reset [*7])
    else $error("reset sequence ended too early");
  a_fall_pin_high: assert property (
    $fell(sys_reset) |-> reset_pin_n && $past(reset_pin_n, 8)
    && !brownout_raw)
    else $error("reset left while a source was active");
  a_pready_once: assert property (
    pready |=> !pready)
    else $error("pready longer than one cycle");
  a_pready_cause: assert property (
    pready |-> psel && penable && $past(psel && penable))
    else $error("pready without access phase");
  a_unmapped_err: assert property (
    pready && paddr > `RSLV_ADDR_IRQ_EN |-> pslverr)
    else $error("unmapped access not refused");
  a_ctrl_wr_cause: assert property (
    wdog_ctrl_wr |-> $past(psel && penable && pwrite
    && paddr == `RSLV_ADDR_CAUSE))
    else $error("watchdog control strobe without write");
endmodule // rslv_core_asserts
bind rslv_core rslv_core_asserts i_rslv_core_asserts (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .reset_pin_n,
  .wdog_timeout, .watchdog_action_option, .brownout_raw, .sys_reset,
  .wdog_ctrl_wr);
`default_nettype wire

// *** rslv_params.svh ***
`ifndef RSLV_PARAMS_SVH
`define RSLV_PARAMS_SVH

// Byte addresses on APB
`define RSLV_ADDR_CAUSE 12'h000
`define RSLV_ADDR_CTRL 12'h004
`define RSLV_ADDR_IRQ_STAT 12'h008
`define RSLV_ADDR_IRQ_CLR 12'h00C
`define RSLV_ADDR_IRQ_EN 12'h010

// Reset-cause register bit positions
`define RSLV_BIT_POR 7
`define RSLV_BIT_STOP 6
`define RSLV_BIT_WDOG 5
`define RSLV_BIT_EXT 4
`define RSLV_BIT_LVD 0
`define RSLV_CAUSE_HI_MASK 8'hF0
`define RSLV_CAUSE_POR_VAL 8'h80

// Control register bits
`define RSLV_CTRL_BO_EN 0
`define RSLV_CTRL_LVD_IE 1
`define RSLV_CTRL_RESET 2'h2

// Interrupt status bits
`define RSLV_IRQ_WDOG 0
`define RSLV_IRQ_LVD 1
`define RSLV_IRQ_W 2

// Timing in system clock cycles
`define RSLV_EXT_MIN_CYC 3'h3
`define RSLV_GLITCH_CYC 3'h3
`define RSLV_SEQ_CYC 4'h8

`endif

// *** rslv_pin_drv.sv ***
`default_nettype none
module rslv_pin_drv (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [3:0] len,
  output logic pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  // Held low for exactly len cycles, pull-up level otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 4'h0;
    else if (go) cnt_r <= len;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
  assign pin_n = (cnt_r == 4'h0);
endmodule // rslv_pin_drv
`default_nettype wire

// *** rslv_pkg.sv ***
`default_nettype none
package rslv_pkg;
  typedef enum logic [1:0] {
    RSLV_RUN = 2'b00,
    RSLV_HOLD = 2'b01,
    RSLV_DONE = 2'b11
  } rslv_seq_e;
  typedef struct packed {
    logic bo_en;
    logic lvd_ie;
  } rslv_ctrl_s;
endpackage
`default_nettype wire

// *** tb_top.sv ***
`include "rslv_params.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic pready, pslverr, pin_n, sys_reset, irq, wdog_ctrl_wr, go = 0;
  logic wdog = 0, opt = 1, stop = 0, bo = 0, lv = 0;
  logic [3:0] len = 4'h1;
  logic [7:0] wdog_ctrl;
  logic [32:0] eq[$], mq[$], e, m;
  int n_mismatch = 0, checks = 0;
  always #5 pclk = ~pclk;
  rslv_pin_drv i_rslv_pin_drv (.pclk, .presetn, .go, .len, .pin_n);
  rslv_core i_rslv_core (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pin_n(pin_n),
    .wdog_timeout(wdog), .watchdog_action_option(opt), .stop_mode(stop),
    .brownout_raw(bo), .low_voltage_raw(lv), .sys_reset, .irq,
    .wdog_ctrl, .wdog_ctrl_wr);
  task results;
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [32:0] s, input logic [32:0] x);
    checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // Answers are judged by the monitor, in issue order
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [32:0] x, input logic [32:0] k);
    int n;
    eq.push_back(x);
    mq.push_back(k);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n == 50) n_mismatch++;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] x, input logic [7:0] k);
    apb(0, a, 32'h0000_0000, {25'h0, x}, {25'h100_0000, k});
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d, 33'h0_0000_0000, 33'h1_0000_0000);
  endtask
  task wsr;
    int n;
    n = 0;
    while (sys_reset !== 1'b0 && n < 100) begin @(posedge pclk); n++; end
    chk({32'h0, sys_reset}, 33'h0);
  endtask
  task pin(input logic [3:0] l);
    go <= 1; len <= l;
    @(posedge pclk);
    go <= 0;
  endtask
  always @(posedge pclk) begin
    if (pready === 1'b1 && eq.size() > 0) begin
      e = eq.pop_front();
      m = mq.pop_front();
      chk({pslverr, prdata} & m, e & m);
    end
  end
  initial begin
    #50us;
    n_mismatch++;
    results;
  end
  initial begin
    r = $urandom(32'h84db);
    cyc(16);
    presetn <= 1;
    cyc(1);
    wsr;
    rd(`RSLV_ADDR_CAUSE, 8'h80, 8'hF0);
    rd(`RSLV_ADDR_CTRL, 8'h01, 8'h03);
    rd(`RSLV_ADDR_CAUSE, 8'h00, 8'hF0);
    apb(0, 12'h020, 0, 33'h1_0000_0000, 33'h1_0000_0000);
    r = $urandom;
    wr(`RSLV_ADDR_CAUSE, r);
    chk({25'h0, wdog_ctrl}, {25'h0, r[7:0]});
    rd(`RSLV_ADDR_CAUSE, 8'h00, 8'hF0);
    wdog <= 1;
    cyc(1);
    wdog <= 0;
    cyc(4);
    chk({32'h0, sys_reset}, 33'h1);
    wsr;
    rd(`RSLV_ADDR_CAUSE, 8'h20, 8'hF0);
    opt <= 0;
    wr(`RSLV_ADDR_IRQ_CLR, 32'h0000_0003);
    wdog <= 1;
    cyc(1);
    wdog <= 0;
    cyc(4);
    chk({31'h0, sys_reset, irq}, 33'h0);
    rd(`RSLV_ADDR_IRQ_STAT, 8'h01, 8'h01);
    wr(`RSLV_ADDR_IRQ_EN, 32'h0000_0001);
    cyc(2);
    chk({32'h0, irq}, 33'h1);
    wr(`RSLV_ADDR_IRQ_CLR, 32'h0000_0001);
    cyc(2);
    chk({32'h0, irq}, 33'h0);
    pin(4'h2);
    cyc(10);
    chk({32'h0, sys_reset}, 33'h0);
    pin(4'h3 + 4'($urandom % 4));
    cyc(11);
    chk({32'h0, sys_reset}, 33'h1);
    wsr;
    rd(`RSLV_ADDR_CAUSE, 8'h10, 8'hF0);
    stop <= 1;
    pin(4'h5);
    cyc(12);
    chk({32'h0, sys_reset}, 33'h1);
    wsr;
    stop <= 0;
    rd(`RSLV_ADDR_CAUSE, 8'h40, 8'h40);
    wr(`RSLV_ADDR_CTRL, 32'h0000_0003);
    wr(`RSLV_ADDR_IRQ_EN, 32'h0000_0002);
    lv <= 1;
    cyc(4);
    rd(`RSLV_ADDR_CAUSE, 8'h01, 8'h01);
    rd(`RSLV_ADDR_CAUSE, 8'h01, 8'h01);
    lv <= 0;
    cyc(4);
    rd(`RSLV_ADDR_CAUSE, 8'h00, 8'h01);
    chk({32'h0, irq}, 33'h1);
    wr(`RSLV_ADDR_IRQ_CLR, 32'h0000_0002);
    wr(`RSLV_ADDR_CTRL, 32'h0000_0002);
    lv <= 1;
    cyc(4);
    rd(`RSLV_ADDR_CAUSE, 8'h00, 8'h01);
    lv <= 0;
    wr(`RSLV_ADDR_CTRL, 32'h0000_0001);
    bo <= 1;
    cyc(6);
    chk({32'h0, sys_reset}, 33'h1);
    bo <= 0;
    wsr;
    rd(`RSLV_ADDR_CAUSE, 8'h80, 8'hF0);
    results;
  end
endmodule // tb_top
`default_nettype wire
